// ===== rtl/dmo_regs.svh
// Offsets, field ranges, masks, reset values and fetch constants
// Assumes byte addresses on a 16-bit Avalon-MM slave address
`ifndef DMO_REGS_SVH
`define DMO_REGS_SVH

// Register byte offsets
`define DMO_OFF_UNLOCK 16'h8300
`define DMO_OFF_CTRL 16'h8304
`define DMO_OFF_STATUS 16'h8308
`define DMO_OFF_FB_PTR 16'h830c
`define DMO_OFF_CB_START 16'h8314
`define DMO_OFF_PTR_START 16'h8318
`define DMO_OFF_RSVD_A 16'h831c
`define DMO_OFF_VID_START 16'h8320
`define DMO_OFF_STRIDE 16'h8324
`define DMO_OFF_BUF_SIZE 16'h8328
`define DMO_OFF_RSVD_B 16'h832c

// Unlock key, arbitrary value
`define DMO_UNLOCK_KEY 32'h00005a5a

// Writable bit masks, reserved bits stay zero
`define DMO_MASK_OFFSET 32'h003fffff
`define DMO_MASK_STRIDE 32'h03ff03ff
`define DMO_MASK_BUF_SIZE 32'h3fffffff
`define DMO_MASK_CTRL 32'h00000003

// Field ranges
`define DMO_OFFSET_RNG 21:0
`define DMO_FB_STRIDE_RNG 9:0
`define DMO_CB_STRIDE_RNG 25:16
`define DMO_VID_LEN_RNG 29:16
`define DMO_CB_LEN_RNG 15:9
`define DMO_FB_LEN_RNG 8:0

// Control and status bit positions
`define DMO_CTRL_FETCH_EN 0
`define DMO_CTRL_CB_EN 1
`define DMO_STAT_CB_OVF 0
`define DMO_STAT_BUSY 1
`define DMO_STAT_LOCKED 2

// Reset value of every register
`define DMO_RST_REG 32'h00000000

// Cursor pattern fetch length in bytes
`define DMO_CURSOR_BYTES 16'h0100

`endif

// ===== rtl/dmo_pkg.sv
// Types shared by the memory organization block
// Assumes nothing beyond a SystemVerilog compiler
package dmo_pkg;

    // Fetch request kinds on the memory controller port
    typedef enum logic [1:0] {
        DMO_KIND_CURSOR = 2'h0,
        DMO_KIND_FB = 2'h1,
        DMO_KIND_CB = 2'h2
    } dmo_kind_e;

    // Fetch sequencer states, one-hot
    typedef enum logic [3:0] {
        DMO_ST_IDLE = 4'b0001,
        DMO_ST_CUR = 4'b0010,
        DMO_ST_FB = 4'b0100,
        DMO_ST_CB = 4'b1000
    } dmo_state_e;

    typedef logic [21:0] dmo_offset_t;

endpackage

// ===== rtl/dmo_beat_gate.sv
// Per-line beat gate: passes the first limit beats of a line, flags the rest
// Assumes line_start pulses once before each line's data
module dmo_beat_gate #(
    parameter int CW = 9,
    parameter int DW = 64
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Line control
    input wire logic line_start,
    input wire logic [CW-1:0] limit,
    // Incoming beats
    input wire logic beat_valid,
    input wire logic [DW-1:0] beat_data,
    // Gated beats and excess pulse
    output logic pass_valid_q,
    output logic [DW-1:0] pass_data_q,
    output logic excess_q
);

    logic [CW-1:0] count_q;
    wire logic in_line = count_q < limit;
    wire logic at_top = &count_q;

    // Count beats in the line; saturates so a runaway line stays excess
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else if (line_start) begin
            count_q <= '0;
        end else if (beat_valid && !at_top) begin
            count_q <= count_q + 1'b1;
        end
    end

    // Register the pass or drop decision
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pass_valid_q <= 1'b0;
            pass_data_q <= '0;
            excess_q <= 1'b0;
        end else begin
            pass_valid_q <= beat_valid && in_line && !line_start;
            pass_data_q <= beat_data;
            excess_q <= beat_valid && !in_line && !line_start;
        end
    end

endmodule

// ===== rtl/dmo_mem_org.sv
// Display memory organization: registers, fetch address sequencer, gating
// Assumes a memory controller that accepts one request at a time and
// a timing block that pulses frame_start and line_start.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`include "dmo_regs.svh"

module dmo_mem_org
    import dmo_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Display timing
    input wire logic frame_start,
    input wire logic line_start,
    input wire logic [21:0] frame_start_offset,
    input wire logic [8:0] active_qwords,
    // Fetch request to memory controller
    output logic req_valid,
    input wire logic req_ready,
    output logic [1:0] req_kind,
    output logic [21:0] req_addr,
    output logic [15:0] req_len,
    // Frame buffer return data and display FIFO write
    input wire logic fb_beat_valid,
    input wire logic [63:0] fb_beat_data,
    output logic fifo_wr_valid,
    output logic [63:0] fifo_wr_data,
    // Compressed return data and compressed FIFO write
    input wire logic cb_beat_valid,
    input wire logic [31:0] cb_beat_data,
    output logic cb_wr_valid,
    output logic [31:0] cb_wr_data,
    // Video buffer geometry for the overlay path, compressed overflow flag
    output logic [21:0] video_start,
    output logic [19:0] video_bytes,
    output logic cb_overflow
);

    // Register state
    logic [31:0] unlock_q;
    logic [31:0] ctrl_q;
    logic [31:0] cb_start_q;
    logic [31:0] ptr_start_q;
    logic [31:0] vid_start_q;
    logic [31:0] stride_q;
    logic [31:0] buf_size_q;
    logic ovf_q;
    logic wait_q;
    logic [31:0] rdata_q;

    // Sequencer state
    dmo_state_e state_q;
    dmo_state_e state_d;
    dmo_offset_t fb_ptr_q;
    dmo_offset_t fb_ptr_d;
    dmo_offset_t cb_ptr_q;
    dmo_offset_t cb_ptr_d;
    logic pend_frame_q;
    logic pend_line_q;
    logic rv_q;
    logic rv_d;
    logic [1:0] rk_q;
    logic [1:0] rk_d;
    dmo_offset_t ra_q;
    dmo_offset_t ra_d;
    logic [15:0] rl_q;
    logic [15:0] rl_d;
    logic take_frame;
    logic take_line;
    logic [21:0] vstart_q;
    logic [19:0] vbytes_q;

    // Gate outputs
    logic cb_excess;

    // Byte-lane merge of a write into the old value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Bus decode: a write lands only on the edge where waitrequest is low
    wire logic commit = avs_write && !wait_q;
    wire logic locked = unlock_q != `DMO_UNLOCK_KEY;
    wire logic wr_open = commit && !locked;
    wire logic hit_unlock = avs_address == `DMO_OFF_UNLOCK;
    wire logic hit_ctrl = avs_address == `DMO_OFF_CTRL;
    wire logic hit_status = avs_address == `DMO_OFF_STATUS;
    wire logic hit_fb_ptr = avs_address == `DMO_OFF_FB_PTR;
    wire logic hit_cb_start = avs_address == `DMO_OFF_CB_START;
    wire logic hit_ptr_start = avs_address == `DMO_OFF_PTR_START;
    wire logic hit_vid_start = avs_address == `DMO_OFF_VID_START;
    wire logic hit_stride = avs_address == `DMO_OFF_STRIDE;
    wire logic hit_buf_size = avs_address == `DMO_OFF_BUF_SIZE;
    wire logic [31:0] wmerge_src = avs_writedata;

    // Field views of the programmed values
    wire logic [9:0] fb_stride = stride_q[`DMO_FB_STRIDE_RNG];
    wire logic [9:0] cb_stride = stride_q[`DMO_CB_STRIDE_RNG];
    wire logic [13:0] vid_len = buf_size_q[`DMO_VID_LEN_RNG];
    wire logic [6:0] cb_len = buf_size_q[`DMO_CB_LEN_RNG];
    wire logic [8:0] fb_len = buf_size_q[`DMO_FB_LEN_RNG];
    wire logic fetch_en = ctrl_q[`DMO_CTRL_FETCH_EN];
    wire logic cb_en = ctrl_q[`DMO_CTRL_CB_EN];
    wire logic busy = state_q != DMO_ST_IDLE;

    // Compressed line holds one DWORD fewer than the programmed length
    wire logic [6:0] cb_valid = (cb_len == 7'h00) ? 7'h00 :
                                cb_len - 7'h01;
    wire logic [15:0] fb_len_bytes = {4'h0, fb_len, 3'b000};
    wire logic [15:0] cb_len_bytes = {7'h00, cb_valid, 2'b00};
    wire logic [21:0] fb_step = {10'h000, fb_stride, 2'b00};
    wire logic [21:0] cb_step = {10'h000, cb_stride, 2'b00};

    // Status view: overflow, busy, lock
    wire logic [31:0] status_view = {29'h0, locked, busy, ovf_q};
    wire logic stat_clr = commit && hit_status && avs_byteenable[0] &&
                          avs_writedata[`DMO_STAT_CB_OVF];

    // Read mux; reserved and unmapped offsets return zero
    wire logic [31:0] rd_mux =
        hit_unlock ? unlock_q :
        hit_ctrl ? ctrl_q :
        hit_status ? status_view :
        hit_fb_ptr ? {10'h000, fb_ptr_q} :
        hit_cb_start ? cb_start_q :
        hit_ptr_start ? ptr_start_q :
        hit_vid_start ? vid_start_q :
        hit_stride ? stride_q :
        hit_buf_size ? buf_size_q :
        32'h00000000;

    // One wait cycle per access, so every answer comes on the second edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((avs_read || avs_write) && wait_q);
        end
    end

    // Read data captured while waitrequest is still high
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (avs_read && wait_q) begin
            rdata_q <= rd_mux;
        end
    end

    // Lock key and control are never locked themselves
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            unlock_q <= `DMO_RST_REG;
            ctrl_q <= `DMO_RST_REG;
        end else begin
            if (commit && hit_unlock) begin
                unlock_q <= merge(unlock_q, wmerge_src, avs_byteenable);
            end
            if (commit && hit_ctrl) begin
                ctrl_q <= merge(ctrl_q, wmerge_src, avs_byteenable) &
                          `DMO_MASK_CTRL;
            end
        end
    end

    // Locked offset registers; masks keep reserved bits at zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cb_start_q <= `DMO_RST_REG;
            ptr_start_q <= `DMO_RST_REG;
            vid_start_q <= `DMO_RST_REG;
        end else begin
            if (wr_open && hit_cb_start) begin
                cb_start_q <= merge(cb_start_q, wmerge_src,
                                    avs_byteenable) & `DMO_MASK_OFFSET;
            end
            if (wr_open && hit_ptr_start) begin
                ptr_start_q <= merge(ptr_start_q, wmerge_src,
                                     avs_byteenable) & `DMO_MASK_OFFSET;
            end
            if (wr_open && hit_vid_start) begin
                vid_start_q <= merge(vid_start_q, wmerge_src,
                                     avs_byteenable) & `DMO_MASK_OFFSET;
            end
        end
    end

    // Locked stride and size registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stride_q <= `DMO_RST_REG;
            buf_size_q <= `DMO_RST_REG;
        end else begin
            if (wr_open && hit_stride) begin
                stride_q <= merge(stride_q, wmerge_src, avs_byteenable) &
                            `DMO_MASK_STRIDE;
            end
            if (wr_open && hit_buf_size) begin
                buf_size_q <= merge(buf_size_q, wmerge_src,
                                    avs_byteenable) & `DMO_MASK_BUF_SIZE;
            end
        end
    end

    // Sticky overflow; a new overflow beats a clear in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= cb_excess || (ovf_q && !stat_clr);
        end
    end

    // Pending frame and line events; a new pulse beats the take
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pend_frame_q <= 1'b0;
            pend_line_q <= 1'b0;
        end else begin
            pend_frame_q <= (frame_start && fetch_en) ||
                            (pend_frame_q && !take_frame);
            pend_line_q <= (line_start && fetch_en) ||
                           (pend_line_q && !take_line && !take_frame);
        end
    end

    // Sequencer: cursor once per frame, then frame line and compressed line
    always_comb begin
        state_d = state_q;
        fb_ptr_d = fb_ptr_q;
        cb_ptr_d = cb_ptr_q;
        rv_d = rv_q;
        rk_d = rk_q;
        ra_d = ra_q;
        rl_d = rl_q;
        take_frame = 1'b0;
        take_line = 1'b0;
        case (state_q)
            DMO_ST_IDLE: begin
                if (pend_frame_q) begin
                    // Frame start reloads both line pointers
                    take_frame = 1'b1;
                    fb_ptr_d = frame_start_offset;
                    cb_ptr_d = cb_start_q[`DMO_OFFSET_RNG];
                    rv_d = 1'b1;
                    rk_d = DMO_KIND_CURSOR;
                    ra_d = ptr_start_q[`DMO_OFFSET_RNG];
                    rl_d = `DMO_CURSOR_BYTES;
                    state_d = DMO_ST_CUR;
                end else if (pend_line_q) begin
                    take_line = 1'b1;
                    rv_d = 1'b1;
                    rk_d = DMO_KIND_FB;
                    ra_d = fb_ptr_q;
                    rl_d = fb_len_bytes;
                    state_d = DMO_ST_FB;
                end
            end
            DMO_ST_CUR: begin
                if (req_ready) begin
                    rv_d = 1'b0;
                    state_d = DMO_ST_IDLE;
                end
            end
            DMO_ST_FB: begin
                if (req_ready) begin
                    fb_ptr_d = fb_ptr_q + fb_step;
                    if (cb_en && cb_valid != 7'h00) begin
                        rk_d = DMO_KIND_CB;
                        ra_d = cb_ptr_q;
                        rl_d = cb_len_bytes;
                        state_d = DMO_ST_CB;
                    end else begin
                        rv_d = 1'b0;
                        state_d = DMO_ST_IDLE;
                    end
                end
            end
            DMO_ST_CB: begin
                if (req_ready) begin
                    cb_ptr_d = cb_ptr_q + cb_step;
                    rv_d = 1'b0;
                    state_d = DMO_ST_IDLE;
                end
            end
            default: begin
                rv_d = 1'b0;
                state_d = DMO_ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= DMO_ST_IDLE;
            fb_ptr_q <= '0;
            cb_ptr_q <= '0;
            rv_q <= 1'b0;
            rk_q <= DMO_KIND_CURSOR;
            ra_q <= '0;
            rl_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            fb_ptr_q <= fb_ptr_d;
            cb_ptr_q <= cb_ptr_d;
            rv_q <= rv_d;
            rk_q <= rk_d;
            ra_q <= ra_d;
            rl_q <= rl_d;
        end
    end

    // Video geometry; length is segments times 64 bytes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vstart_q <= '0;
            vbytes_q <= 20'h00000;
        end else begin
            vstart_q <= vid_start_q[`DMO_OFFSET_RNG];
            vbytes_q <= {vid_len, 6'h00};
        end
    end

    // Frame data past the active line width never reaches the FIFO
    dmo_beat_gate #(
        .CW(9),
        .DW(64)
    ) u_fb_gate (
        .clock(clock),
        .rst(rst),
        .line_start(line_start),
        .limit(active_qwords),
        .beat_valid(fb_beat_valid),
        .beat_data(fb_beat_data),
        .pass_valid_q(fifo_wr_valid),
        .pass_data_q(fifo_wr_data),
        .excess_q()
    );

    // Compressed data beyond the valid DWORDs is an overflow
    dmo_beat_gate #(
        .CW(7),
        .DW(32)
    ) u_cb_gate (
        .clock(clock),
        .rst(rst),
        .line_start(line_start),
        .limit(cb_valid),
        .beat_valid(cb_beat_valid),
        .beat_data(cb_beat_data),
        .pass_valid_q(cb_wr_valid),
        .pass_data_q(cb_wr_data),
        .excess_q(cb_excess)
    );

    // Output drive, all from flip-flops
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign req_valid = rv_q;
    assign req_kind = rk_q;
    assign req_addr = ra_q;
    assign req_len = rl_q;
    assign video_start = vstart_q;
    assign video_bytes = vbytes_q;
    assign cb_overflow = ovf_q;

endmodule

// ===== sim/dmo_mem_org_properties.sv
// Concurrent checks on the memory organization block ports
// Assumes binding to dmo_mem_org; one clock domain, reset active high
module dmo_mem_org_chk
    import dmo_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register bus
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Fetch request
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [1:0] req_kind,
    input wire logic [15:0] req_len,
    // Returned data, gated writes, video size and overflow flag
    input wire logic fb_beat_valid,
    input wire logic [63:0] fb_beat_data,
    input wire logic fifo_wr_valid,
    input wire logic [63:0] fifo_wr_data,
    input wire logic cb_beat_valid,
    input wire logic [19:0] video_bytes,
    input wire logic cb_overflow
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // Software clear of the sticky overflow flag, taken when the bus answers
    wire ovf_clear = avs_write && !avs_waitrequest &&
        avs_address == 16'h8308 && avs_writedata[0] && avs_byteenable[0];

    a_bus_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not one cycle after request");
    a_rsvd_reads_zero: assert property (
        avs_read && !avs_waitrequest &&
        (avs_address == 16'h831c || avs_address == 16'h832c)
        |-> avs_readdata == 32'h00000000)
        else $error("reserved location read nonzero");
    a_req_held: assert property (
        req_valid && !req_ready |=> req_valid && $stable(req_kind) &&
        $stable(req_len))
        else $error("fetch request changed before accept");
    a_cursor_block: assert property (
        req_valid && req_kind == DMO_KIND_CURSOR |-> req_len == 16'h0100)
        else $error("cursor fetch length wrong");
    a_fb_qwords: assert property (
        req_valid && req_kind == DMO_KIND_FB |-> req_len[2:0] == 3'h0)
        else $error("frame line length not whole qwords");
    a_fifo_follows: assert property (
        fifo_wr_valid |-> $past(fb_beat_valid) &&
        fifo_wr_data == $past(fb_beat_data))
        else $error("fifo write without matching beat");
    a_ovf_sticky: assert property (
        cb_overflow && !ovf_clear |=> cb_overflow)
        else $error("overflow flag dropped without clear");
    a_ovf_cause: assert property (
        $rose(cb_overflow) |-> $past(cb_beat_valid, 2))
        else $error("overflow set without compressed beat");
    a_video_segs: assert property (
        video_bytes[5:0] == 6'h00)
        else $error("video size not whole 64 byte segments");

    // Main scenarios reached
    c_cb_accept: cover property (req_valid && req_ready && req_kind == DMO_KIND_CB);
    c_overflow: cover property ($rose(cb_overflow));
    c_stall: cover property (req_valid && !req_ready);
endmodule

// ===== sim/dmo_mem_model.sv
// Memory controller stand-in: accepts fetch requests, streams data back
// Assumes the block holds each request until an accept edge
module dmo_mem_model
    import dmo_pkg::*;
(
    // Clock
    input wire logic clock,
    // Fetch request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_kind,
    input wire logic [21:0] req_addr,
    input wire logic [15:0] req_len,
    // Returned beats
    output logic fb_beat_valid,
    output logic [63:0] fb_beat_data,
    output logic cb_beat_valid,
    output logic [31:0] cb_beat_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic slow = 1'b0;
    logic busy = 1'b0;
    int extra = 0;
    int n_req = 0;
    logic [1:0] k_log [8];
    logic [21:0] a_log [8];
    logic [15:0] l_log [8];

    // Extra beats past the line end let the bench see them dropped
    task automatic send(input logic [1:0] k, input logic [15:0] len);
        int n;
        n = (k == DMO_KIND_FB) ? int'(len) / 8 + extra :
            (k == DMO_KIND_CB) ? int'(len) / 4 + extra : 0;
        for (int i = 0; i < n; i++) begin
            fb_beat_valid <= (k == DMO_KIND_FB);
            cb_beat_valid <= (k == DMO_KIND_CB);
            fb_beat_data <= 64'(req_addr) + 64'(i);
            cb_beat_data <= 32'h00000100 + 32'(i);
            @(posedge clock);
        end
        fb_beat_valid <= 1'b0;
        cb_beat_valid <= 1'b0;
        fb_beat_data <= ~fb_beat_data; // Released lines do not keep data
        cb_beat_data <= ~cb_beat_data;
        @(posedge clock);
    endtask

    // One request at a time; slow mode stalls the accept
    initial begin
        req_ready = 1'b0;
        fb_beat_valid = 1'b0;
        cb_beat_valid = 1'b0;
        fb_beat_data = '1;
        cb_beat_data = '1;
        forever begin
            @(posedge clock);
            if (req_valid === 1'b1) begin
                busy <= 1'b1;
                if (slow) repeat (3) @(posedge clock);
                req_ready <= 1'b1;
                @(posedge clock);
                k_log[n_req] = req_kind;
                a_log[n_req] = req_addr;
                l_log[n_req] = req_len;
                n_req++;
                req_ready <= 1'b0;
                send(req_kind, req_len);
                busy <= 1'b0;
            end
        end
    end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the memory organization block
// Assumes the memory controller stand-in and the port checker
`include "dmo_regs.svh"

bind dmo_mem_org dmo_mem_org_chk u_chk (.clock, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .req_valid, .req_ready, .req_kind, .req_len,
    .fb_beat_valid, .fb_beat_data, .fifo_wr_valid, .fifo_wr_data,
    .cb_beat_valid, .video_bytes, .cb_overflow);

module tb_top
    import dmo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rst, avs_read, avs_write, avs_waitrequest;
    logic frame_start, line_start, req_valid, req_ready, fb_beat_valid;
    logic fifo_wr_valid, cb_beat_valid, cb_wr_valid, cb_overflow;
    logic [15:0] avs_address, req_len;
    logic [31:0] avs_writedata, avs_readdata, cb_beat_data, cb_wr_data, rd;
    logic [63:0] fb_beat_data, fifo_wr_data;
    logic [1:0] req_kind;
    logic [21:0] req_addr, video_start;
    logic [19:0] video_bytes;
    int n_fail = 0;
    int comparisons = 0;
    int n_fifo = 0;
    int n_cbw = 0;
    // Write value and expected read back, reserved bits cleared
    localparam logic [15:0] reg_a [8] = '{16'h8320, 16'h8324, 16'h8328,
        16'h8318, 16'h8314, 16'h831c, 16'h832c, 16'h8400};
    localparam logic [31:0] reg_w [8] = '{32'hffc12340, 32'hfc100020,
        32'hc0100a04, 32'hffc01000, 32'hffc02000, '1, '1, '1};
    localparam logic [31:0] reg_e [8] = '{32'h00012340, 32'h00100020,
        32'h00100a04, 32'h00001000, 32'h00002000, '0, '0, '0};

    dmo_mem_org u_dut (.clock, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .frame_start, .line_start,
        .frame_start_offset(22'h004000), .active_qwords(9'h002), .req_valid,
        .req_ready, .req_kind, .req_addr, .req_len, .fb_beat_valid,
        .fb_beat_data, .fifo_wr_valid, .fifo_wr_data, .cb_beat_valid,
        .cb_beat_data, .cb_wr_valid, .cb_wr_data, .video_start, .video_bytes,
        .cb_overflow);
    dmo_mem_model u_mem (.clock, .req_valid, .req_ready, .req_kind,
        .req_addr, .req_len, .fb_beat_valid, .fb_beat_data, .cb_beat_valid,
        .cb_beat_data);

    task automatic finish_test();
        $display("Mismatches %0d, comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One bus access; held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [15:0] a,
            input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clock);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        rd = avs_readdata;
        chk({31'h0, avs_waitrequest}, 32'h0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Waits, bounded, until the model has taken n requests and gone quiet
    task automatic wait_req(input int n);
        int t;
        t = 0;
        while ((u_mem.n_req < n || u_mem.busy) && t < 300) begin
            @(posedge clock);
            t++;
        end
        if (t >= 300) chk(32'(t), 32'h0);
    endtask

    task automatic pulse(input logic frame);
        @(posedge clock);
        frame_start <= frame;
        line_start <= !frame;
        @(posedge clock);
        frame_start <= 1'b0;
        line_start <= 1'b0;
    endtask

    task automatic chk_req(input int i, input logic [1:0] k,
            input logic [21:0] a, input logic [15:0] l);
        chk({8'h00, u_mem.a_log[i], u_mem.k_log[i]}, {8'h00, a, k});
        chk({16'h0000, u_mem.l_log[i]}, {16'h0000, l});
    endtask

    // Clock at 100 ns period
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Count gated writes to both FIFOs
    always @(posedge clock) begin
        if (fifo_wr_valid === 1'b1) n_fifo++;
        if (cb_wr_valid === 1'b1) n_cbw++;
        if (cb_wr_valid === 1'b1)
            chk(cb_wr_data & 32'hfffffff8, 32'h100);
    end

    // Hang guard, far beyond the hundred or so cycles the tests take
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 16'h0000;
        avs_writedata = 32'h00000000;
        frame_start = 1'b0;
        line_start = 1'b0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        bus(0, 16'h8308, 0);
        chk(rd & 32'h00000004, 32'h00000004);
        bus(1, 16'h8320, 32'h00012340);
        bus(0, 16'h8320, 0);
        chk(rd, 32'h00000000);
        bus(1, 16'h8300, `DMO_UNLOCK_KEY);
        for (int i = 0; i < 8; i++) begin
            bus(1, reg_a[i], reg_w[i]);
            bus(0, reg_a[i], 0);
            chk(rd, reg_e[i]);
        end
        chk(32'(video_start), 32'h00012340);
        chk(32'(video_bytes), 32'h00000400);
        bus(1, 16'h8304, 32'h00000003);
        u_mem.slow = 1'b1;
        pulse(1);
        wait_req(1);
        chk_req(0, DMO_KIND_CURSOR, 22'h001000, 16'h0100);
        u_mem.slow = 1'b0;
        pulse(0);
        wait_req(3);
        chk_req(1, DMO_KIND_FB, 22'h004000, 16'h0020);
        chk_req(2, DMO_KIND_CB, 22'h002000, 16'h0010);
        chk(32'(n_fifo), 32'h2);
        chk(32'(n_cbw) + 32'(cb_overflow), 32'h4);
        u_mem.extra = 1;
        pulse(0);
        wait_req(5);
        chk_req(3, DMO_KIND_FB, 22'h004080, 16'h0020);
        chk_req(4, DMO_KIND_CB, 22'h002040, 16'h0010);
        chk(32'(n_fifo) + 32'(n_cbw), 32'hc);
        chk(32'(cb_overflow), 32'h1);
        bus(1, 16'h8308, 32'h00000001);
        bus(0, 16'h8308, 0);
        chk(rd & 32'h00000001, 32'h00000000);
        bus(1, 16'h8300, 32'h00000000);
        bus(1, 16'h8324, 32'h00000000);
        bus(0, 16'h8324, 0);
        chk(rd, 32'h00100020);
        finish_test();
    end
endmodule
